// >>> psd_pkg.sv
/*
 * constants, field layouts and state codes for the pwm shutdown, dead-band
 * and steering output stage. assumes a single 25 MHz instruction clock and
 * a classic wishbone slave port with byte addresses.
 */
// Contract
// RULE_01 - bit 7 flags shutdown held, zero normal
// RULE_02 - three-bit field selects comparators and interrupt pin
// RULE_03 - pair a/c shutdown: low, high, or tri-state
// RULE_04 - pair b/d shutdown in bits 1-0, same coding
// RULE_05 - comparator two shutdown waits for timer edge
// RULE_06 - trigger is a level, shutdown persists with it
// RULE_07 - flag writes ignored while trigger stays asserted
// RULE_08 - restart resumes output at next period start
// RULE_09 - auto restart clears flag once trigger gone
// RULE_10 - without auto restart software clears the flag
// RULE_11 - half-bridge delay only on inactive-to-active edges
// RULE_12 - seven-bit count sets delay in instruction cycles
// RULE_13 - steering only in single-output pwm mode
// RULE_14 - one pwm signal routed to any pin set
// RULE_15 - polarity bits apply to all steered pins
// RULE_16 - shutdown touches only steering-enabled pins
// RULE_17 - shutdown states applied at once, no clock wait
// RULE_18 - software setting the flag forces a shutdown
// RULE_19 - steering bit set drives pwm, clear gives port
// RULE_20 - delay restarts each edge, zero none, long blanks
package psd_pkg;
    // register byte addresses
    localparam logic [7:0] ADR_SHUTDOWN = 8'h00;
    localparam logic [7:0] ADR_RESTART = 8'h04;
    localparam logic [7:0] ADR_CCP = 8'h08;
    localparam logic [7:0] ADR_STEER = 8'h0C;
    localparam logic [7:0] ADR_SYNC = 8'h10;
    localparam logic [7:0] ADR_STATUS = 8'h14;
    // reset values
    localparam logic [7:0] RST_SHUTDOWN = 8'h00;
    localparam logic [7:0] RST_RESTART = 8'h00;
    localparam logic [7:0] RST_CCP = 8'h00;
    localparam logic [3:0] RST_STEER = 4'h1;
    // auto_shutdown_control fields
    localparam int FLAG_BIT = 7;
    localparam int SRC_MSB = 6;
    localparam int SRC_LSB = 4;
    localparam int AC_MSB = 3;
    localparam int AC_LSB = 2;
    localparam int BD_MSB = 1;
    localparam int BD_LSB = 0;
    localparam int SRC_CMP_ONE = 0;
    localparam int SRC_CMP_TWO = 1;
    localparam int SRC_INT = 2;
    localparam int STATE_TRI = 1;
    localparam int STATE_LVL = 0;
    // restart_deadband_control fields
    localparam int AUTO_BIT = 7;
    localparam int DBC_MSB = 6;
    localparam int DBC_LSB = 0;
    // capture_compare_pwm_control fields
    localparam int CFG_MSB = 7;
    localparam int CFG_LSB = 6;
    localparam int MODE_MSB = 3;
    localparam int MODE_LSB = 2;
    localparam int POL_AC = 1;
    localparam int POL_BD = 0;
    localparam logic [1:0] MODE_PWM = 2'h3;
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_FULL_FWD = 2'h1;
    localparam logic [1:0] CFG_HALF = 2'h2;
    localparam logic [1:0] CFG_FULL_REV = 2'h3;
    localparam logic [3:0] EN_NONE = 4'h0;
    localparam logic [3:0] EN_HALF = 4'h3;
    localparam logic [3:0] EN_FULL = 4'hF;
    localparam int SYNC_BIT = 0;
    // shutdown sequencing states
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_SHUT = 3'h2,
        ST_HOLD = 3'h4
    } psd_state_t;
endpackage : psd_pkg

// >>> psd_top.sv
/*
 * output stage of an enhanced pwm: auto-shutdown with restart, half-bridge
 * dead-band, full-bridge pin drive and single-output pulse steering.
 * assumes the raw duty waveform and a period-start pulse come from the
 * period generator, that all inputs are synchronous to CLOCK, and that a
 * pad ring resolves each pin from its value and enable.
 */
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module psd_top (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // shutdown sources
    input wire logic COMPARATOR_ONE,
    input wire logic COMPARATOR_TWO,
    input wire logic INT_PIN,
    input wire logic TIMER_SYNC,
    // from the period generator
    input wire logic PWM_RAW,
    input wire logic PERIOD_START,
    // general-purpose port function, bit 0 is pin a
    input wire logic [3:0] PORT_DATA,
    input wire logic [3:0] PORT_OE,
    // output pins
    output logic PWM_OUT_A,
    output logic PWM_OUT_B,
    output logic PWM_OUT_C,
    output logic PWM_OUT_D,
    output logic PWM_OE_A,
    output logic PWM_OE_B,
    output logic PWM_OE_C,
    output logic PWM_OE_D
);
    logic [7:0] asc_q;
    logic [7:0] rdc_q;
    logic [7:0] ccp_q;
    logic [3:0] steer_q;
    logic cmp_two_sync_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic flag_q;
    logic flag_d;
    logic hw_q;
    logic cmp_two_held_q;
    psd_pkg::psd_state_t state_q;
    psd_pkg::psd_state_t state_d;
    logic wb_req;
    logic wr_any;
    logic wr_asc;
    logic cmp_two_eff;
    logic trig;
    logic forced;
    logic [2:0] src;
    logic [1:0] ac_state;
    logic [1:0] bd_state;
    logic [6:0] dbc;
    logic [1:0] cfg;
    logic pwm_mode;
    logic [1:0] sched;
    logic [1:0] dly_act;
    logic [3:0] act;
    logic [3:0] en;
    logic [3:0] pol_low;
    logic [3:0] pwm_val_q;
    logic [3:0] pwm_en_q;
    logic [3:0] pin_val;
    logic [3:0] pin_oe;
    logic [7:0] rbyte;

    // field views
    assign src = asc_q[psd_pkg::SRC_MSB:psd_pkg::SRC_LSB];
    assign ac_state = asc_q[psd_pkg::AC_MSB:psd_pkg::AC_LSB];
    assign bd_state = asc_q[psd_pkg::BD_MSB:psd_pkg::BD_LSB];
    assign dbc = rdc_q[psd_pkg::DBC_MSB:psd_pkg::DBC_LSB];
    assign cfg = ccp_q[psd_pkg::CFG_MSB:psd_pkg::CFG_LSB];
    assign pwm_mode = (ccp_q[psd_pkg::MODE_MSB:psd_pkg::MODE_LSB] == psd_pkg::MODE_PWM);

    // bus strobes: one request per ack, writes land on the lowest byte lane
    assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
    assign wr_any = wb_req & WB_WE_I & WB_SEL_I[0];
    assign wr_asc = wr_any & (WB_ADR_I == psd_pkg::ADR_SHUTDOWN);

    // bus acknowledge, one cycle after the strobe, dropped the cycle after
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        case (WB_ADR_I)
            psd_pkg::ADR_SHUTDOWN: rbyte = {flag_q, asc_q[psd_pkg::SRC_MSB:0]}; // RULE_01
            psd_pkg::ADR_RESTART: rbyte = rdc_q;
            psd_pkg::ADR_CCP: rbyte = ccp_q;
            psd_pkg::ADR_STEER: rbyte = {4'h0, steer_q};
            psd_pkg::ADR_SYNC: rbyte = {7'h00, cmp_two_sync_q};
            psd_pkg::ADR_STATUS: rbyte = {4'h0, trig, state_q};
            default: rbyte = 8'h00;
        endcase
    end

    // read data register, captured with the acknowledge
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= 32'h0000_0000;
        end else if (wb_req & ~WB_WE_I) begin
            rdata_q <= {24'h00_0000, rbyte};
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdata_q;

    // configuration registers; the flag bit of asc_q is unused storage
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            asc_q <= psd_pkg::RST_SHUTDOWN;
            rdc_q <= psd_pkg::RST_RESTART;
            ccp_q <= psd_pkg::RST_CCP;
            steer_q <= psd_pkg::RST_STEER;
            cmp_two_sync_q <= 1'b0;
        end else if (wr_any) begin
            case (WB_ADR_I)
                psd_pkg::ADR_SHUTDOWN: asc_q <= {1'b0, WB_DAT_I[psd_pkg::SRC_MSB:0]};
                psd_pkg::ADR_RESTART: rdc_q <= WB_DAT_I[7:0];
                psd_pkg::ADR_CCP: ccp_q <= WB_DAT_I[7:0];
                psd_pkg::ADR_STEER: steer_q <= WB_DAT_I[3:0];
                psd_pkg::ADR_SYNC: cmp_two_sync_q <= WB_DAT_I[psd_pkg::SYNC_BIT];
                default: asc_q <= asc_q;
            endcase
        end
    end

    // comparator two sampled on the timer edge when synchronised
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            cmp_two_held_q <= 1'b0;
        end else if (TIMER_SYNC) begin
            cmp_two_held_q <= COMPARATOR_TWO; // RULE_05
        end
    end

    assign cmp_two_eff = cmp_two_sync_q ? cmp_two_held_q : COMPARATOR_TWO; // RULE_05

    // level trigger from the selected sources
    assign trig = (src[psd_pkg::SRC_CMP_ONE] & COMPARATOR_ONE) // RULE_02
        | (src[psd_pkg::SRC_CMP_TWO] & cmp_two_eff)
        | (src[psd_pkg::SRC_INT] & ~INT_PIN); // RULE_06

    // shutdown flag: trigger beats any write, auto restart clears hw events
    always_comb begin
        if (trig) begin
            flag_d = 1'b1; // RULE_06 RULE_07
        end else if (wr_asc) begin
            flag_d = WB_DAT_I[psd_pkg::FLAG_BIT]; // RULE_10 RULE_18
        end else if (rdc_q[psd_pkg::AUTO_BIT] & hw_q) begin
            flag_d = 1'b0; // RULE_09
        end else begin
            flag_d = flag_q;
        end
    end

    // flag register and a note of whether hardware caused it
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            flag_q <= 1'b0;
            hw_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            hw_q <= trig | (hw_q & flag_d);
        end
    end

    // shutdown sequence: run, shut, hold until the next period start
    always_comb begin
        case (state_q)
            psd_pkg::ST_RUN: state_d = (trig | flag_q) ? psd_pkg::ST_SHUT : psd_pkg::ST_RUN;
            psd_pkg::ST_SHUT: state_d = (trig | flag_q) ? psd_pkg::ST_SHUT : psd_pkg::ST_HOLD;
            psd_pkg::ST_HOLD: begin
                if (trig | flag_q) begin
                    state_d = psd_pkg::ST_SHUT;
                end else if (PERIOD_START) begin
                    state_d = psd_pkg::ST_RUN; // RULE_08
                end else begin
                    state_d = psd_pkg::ST_HOLD;
                end
            end
            default: state_d = psd_pkg::ST_SHUT;
        endcase
    end

    // state register
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= psd_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs forced while triggered, from the cycle after the flag sets, or while waiting for a period
    assign forced = trig | (state_q != psd_pkg::ST_RUN); // RULE_17 RULE_08

    // scheduled active levels of the two half-bridge outputs
    assign sched = {~PWM_RAW, PWM_RAW};

    // dead-band delay on each rising scheduled edge, one per output
    for (genvar g = 0; g < 2; g++) begin : g_dead
        logic [6:0] cnt_q;
        logic prev_q;
        logic rise;
        assign rise = sched[g] & ~prev_q;
        assign dly_act[g] = sched[g] & (rise ? (dbc == 7'h00) : (cnt_q == 7'h00)); // RULE_11 RULE_20
        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                cnt_q <= 7'h00;
                prev_q <= 1'b0;
            end else begin
                prev_q <= sched[g];
                if (!sched[g]) begin
                    cnt_q <= 7'h00; // RULE_11
                end else if (rise) begin
                    cnt_q <= (dbc == 7'h00) ? 7'h00 : dbc - 7'h01; // RULE_12 RULE_20
                end else if (cnt_q != 7'h00) begin
                    cnt_q <= cnt_q - 7'h01;
                end
            end
        end
    end

    // per-pin active level and pwm ownership by output configuration
    always_comb begin
        act = 4'h0;
        en = psd_pkg::EN_NONE;
        if (pwm_mode) begin
            case (cfg)
                psd_pkg::CFG_SINGLE: begin
                    act = {4{PWM_RAW}}; // RULE_13 RULE_14
                    en = steer_q; // RULE_19
                end
                psd_pkg::CFG_HALF: begin
                    act = {2'h0, dly_act}; // RULE_11
                    en = psd_pkg::EN_HALF;
                end
                psd_pkg::CFG_FULL_FWD: begin
                    act = {PWM_RAW, 2'h0, 1'b1};
                    en = psd_pkg::EN_FULL;
                end
                psd_pkg::CFG_FULL_REV: begin
                    act = {1'b0, 1'b1, PWM_RAW, 1'b0};
                    en = psd_pkg::EN_FULL;
                end
                default: begin
                    act = 4'h0;
                    en = psd_pkg::EN_NONE;
                end
            endcase
        end
    end

    // polarity per pair, a/c and b/d, also used for all steered pins
    assign pol_low = {ccp_q[psd_pkg::POL_BD], ccp_q[psd_pkg::POL_AC],
        ccp_q[psd_pkg::POL_BD], ccp_q[psd_pkg::POL_AC]}; // RULE_15

    // registered normal drive
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            pwm_val_q <= 4'h0;
            pwm_en_q <= 4'h0;
        end else begin
            pwm_val_q <= act ^ pol_low; // RULE_15
            pwm_en_q <= en;
        end
    end

    // pin mux: shutdown state, pwm drive or port function
    for (genvar p = 0; p < 4; p++) begin : g_pin
        logic [1:0] sd;
        assign sd = (p % 2 == 0) ? ac_state : bd_state; // RULE_03 RULE_04
        always_comb begin
            if (pwm_en_q[p] & forced) begin
                pin_val[p] = sd[psd_pkg::STATE_LVL] & ~sd[psd_pkg::STATE_TRI]; // RULE_16 RULE_17
                pin_oe[p] = ~sd[psd_pkg::STATE_TRI]; // RULE_03 RULE_04
            end else if (pwm_en_q[p]) begin
                pin_val[p] = pwm_val_q[p];
                pin_oe[p] = 1'b1;
            end else begin
                pin_val[p] = PORT_DATA[p]; // RULE_19
                pin_oe[p] = PORT_OE[p];
            end
        end
    end

    assign {PWM_OUT_D, PWM_OUT_C, PWM_OUT_B, PWM_OUT_A} = pin_val;
    assign {PWM_OE_D, PWM_OE_C, PWM_OE_B, PWM_OE_A} = pin_oe;

    // checks on the shutdown, dead-band and steering paths
    a_trig_sets_flag: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_06
        trig |=> flag_q) else $error("trigger did not set shutdown flag");
    a_write_ignored: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_07
        (wr_asc && !WB_DAT_I[psd_pkg::FLAG_BIT] && trig) |=> flag_q)
        else $error("flag cleared under trigger");
    a_sw_set: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_18
        (wr_asc && WB_DAT_I[7]) |=> (flag_q ##1 (state_q == psd_pkg::ST_SHUT)))
        else $error("software set did not shut down");
    a_auto_clear: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_09
        (flag_q && hw_q && rdc_q[psd_pkg::AUTO_BIT] && !trig && !wr_asc) |=> !flag_q)
        else $error("auto restart did not clear flag");
    a_hold_period: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_08
        (state_q == psd_pkg::ST_HOLD && !PERIOD_START) |=> (state_q != psd_pkg::ST_RUN))
        else $error("resumed before period start");
    a_force_pin_a: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_17
        (trig && pwm_en_q[0] && !ac_state[1]) |-> (PWM_OE_A && PWM_OUT_A == ac_state[0]))
        else $error("pin a not in shutdown state");
    a_tristate_b: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_04
        (forced && pwm_en_q[1] && bd_state[1]) |-> !PWM_OE_B)
        else $error("pin b not released");
    a_port_kept: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_16
        (!pwm_en_q[2]) |-> (PWM_OE_C == PORT_OE[2] && PWM_OUT_C == PORT_DATA[2]))
        else $error("port pin c disturbed");
    a_cmp_two_sync: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_05
        (cmp_two_sync_q && src == 3'h2 && !cmp_two_held_q && !TIMER_SYNC) |-> !trig)
        else $error("comparator two not synchronised");
    a_dead_zero: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_20
        ($rose(PWM_RAW) && dbc == 7'h00) |-> dly_act[0]) else $error("zero delay delayed");
    a_dead_delay: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_12
        ($rose(PWM_RAW) && dbc == 7'h02) |-> (!dly_act[0] ##1 (!dly_act[0] || !PWM_RAW)
        ##1 (dly_act[0] || !PWM_RAW))) else $error("dead-band count wrong");
    a_fall_now: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_11
        (!sched[0]) |-> !dly_act[0]) else $error("inactive edge delayed");
    a_steer_only: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_13
        (pwm_mode && cfg == psd_pkg::CFG_SINGLE) |=> (pwm_en_q == $past(steer_q)))
        else $error("steering mask wrong");
endmodule : psd_top

// >>> psd_far.sv
/*
 * far-side model: power switch drivers seen as pads with pull-downs, and
 * the comparator, interrupt-pin and timer sources that trip a shutdown.
 * assumes the bench commands each trip and timer pulse at a clock edge.
 */
`timescale 1ns/1ps
module psd_far (
    // design pins
    input wire logic [3:0] pin_val,
    input wire logic [3:0] pin_oe,
    // bench commands
    input wire logic trip_cmp_one,
    input wire logic trip_cmp_two,
    input wire logic trip_int,
    input wire logic sync_cmd,
    // resolved pads and sources
    output logic [3:0] pad,
    output logic cmp_one,
    output logic cmp_two,
    output logic int_pin,
    output logic timer_sync
);
    // a released pad falls to the board pull-down, never keeps its last value
    assign pad = pin_oe & pin_val;
    // comparators go high on a trip
    assign cmp_one = trip_cmp_one;
    assign cmp_two = trip_cmp_two;
    // interrupt pin is pulled up and pulled low on a trip
    assign int_pin = ~trip_int;
    assign timer_sync = sync_cmd;
endmodule : psd_far

// >>> psd_top_tb.sv
/*
 * self-checking bench for the pwm output stage: register access, shutdown
 * sources and restart, steering, dead-band. assumes psd_pkg and psd_far.
 */
`timescale 1ns/1ps
module psd_top_tb;
    logic clk, rst_b, cyc, stb, we, raw, pstart, t1, t2, ti, ts, hi;
    logic [7:0] adr, rd;
    logic [3:0] sel, pdat, poe;
    logic [31:0] wdat;
    wire [31:0] dat_o;
    wire ack, cmp_one, cmp_two, ipin, tsync;
    wire [3:0] pv, po, pad;
    int n_fail, compares, cycles, k;
    logic [7:0] radr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h30};
    logic [7:0] rval [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    // full forward, full reverse, then port and steering settings
    logic [7:0] sccp [9] = '{8'h4C, 8'hCC, 8'h00, 8'h08, 8'h0C, 8'h0F, 8'h0D, 8'h0C, 8'h0C};
    logic [3:0] sstr [9] = '{4'h0, 4'h0, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h9, 4'h0};
    logic [3:0] slvl [9] = '{4'h9, 4'h6, 4'h2, 4'h2, 4'hF, 4'h0, 4'h5, 4'hB, 4'h2};
    logic [7:0] tdat [3] = '{8'h88, 8'h8E, 8'h84};
    logic [3:0] tlvl [3] = '{4'h0, 4'h0, 4'h5};
    logic [3:0] toe [3] = '{4'hA, 4'h0, 4'hF};

    psd_top i_psd_top (.CLOCK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .COMPARATOR_ONE(cmp_one), .COMPARATOR_TWO(cmp_two), .INT_PIN(ipin),
        .TIMER_SYNC(tsync), .PWM_RAW(raw), .PERIOD_START(pstart), .PORT_DATA(pdat),
        .PORT_OE(poe), .PWM_OUT_A(pv[0]), .PWM_OUT_B(pv[1]), .PWM_OUT_C(pv[2]),
        .PWM_OUT_D(pv[3]), .PWM_OE_A(po[0]), .PWM_OE_B(po[1]), .PWM_OE_C(po[2]),
        .PWM_OE_D(po[3]));
    psd_far i_psd_far (.pin_val(pv), .pin_oe(po), .trip_cmp_one(t1), .trip_cmp_two(t2),
        .trip_int(ti), .sync_cmd(ts), .pad(pad), .cmp_one(cmp_one), .cmp_two(cmp_two),
        .int_pin(ipin), .timer_sync(tsync));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask : check

    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= 4'h1;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string n);
        wb(1'b0, a, 8'h00);
        check(n, e, rd);
    endtask : rdchk

    task automatic sdw(input logic [7:0] d);
        wb(1'b1, psd_pkg::ADR_SHUTDOWN, d);
    endtask : sdw

    // pad levels and enables once combinational paths settle
    task automatic pins(input logic [3:0] l, input logic [3:0] o);
        #1;
        check("pin level", {4'h0, l}, {4'h0, pad});
        check("pin enable", {4'h0, o}, {4'h0, po});
    endtask : pins

    task automatic period;
        @(posedge clk);
        pstart <= 1'b1;
        @(posedge clk);
        pstart <= 1'b0;
        @(posedge clk);
    endtask : period

    task automatic tsync_pulse;
        @(posedge clk);
        ts <= 1'b1;
        @(posedge clk);
        ts <= 1'b0;
    endtask : tsync_pulse

    // main sequence
    initial begin
        {rst_b, cyc, stb, we, raw, pstart, t1, t2, ti, ts} = 10'h0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        pdat = 4'h2;
        poe = 4'hF;
        n_fail = 0;
        compares = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        raw <= 1'b1;
        for (int i = 0; i < 6; i++) rdchk(radr[i], rval[i], "reset value");
        $display("test reset values done");
        for (int i = 0; i < 9; i++) begin
            wb(1'b1, psd_pkg::ADR_CCP, sccp[i]);
            wb(1'b1, psd_pkg::ADR_STEER, {4'h0, sstr[i]});
            pins(slvl[i], 4'hF);
        end
        wb(1'b1, psd_pkg::ADR_STEER, 8'h01);
        sdw(8'h80);
        pins(4'h2, 4'hF);
        sdw(8'h00);
        period();
        pins(4'h3, 4'hF);
        $display("test steering done");
        raw <= 1'b0;
        wb(1'b1, psd_pkg::ADR_STEER, 8'h0F);
        wb(1'b1, psd_pkg::ADR_RESTART, 8'h80);
        sdw(8'h01);
        {t1, t2, ti} <= 3'h7;
        pins(4'h0, 4'hF);
        // sources quiet before each new selection lands
        {t1, t2, ti} <= 3'h0;
        for (int s = 1; s < 8; s++) begin
            sdw({1'b0, s[2:0], 4'h1});
            {t1, t2, ti} <= {~s[0], ~s[1], ~s[2]};
            pins(4'h0, 4'hF);
            @(posedge clk);
            {t1, t2, ti} <= {s[0], s[1], s[2]};
            pins(4'hA, 4'hF);
            rdchk(psd_pkg::ADR_SHUTDOWN, {1'b1, s[2:0], 4'h1}, "flag set");
            {t1, t2, ti} <= 3'h0;
            repeat (3) @(posedge clk);
            rdchk(psd_pkg::ADR_SHUTDOWN, {1'b0, s[2:0], 4'h1}, "auto clear");
            period();
            pins(4'h0, 4'hF);
        end
        $display("test shutdown sources done");
        wb(1'b1, psd_pkg::ADR_RESTART, 8'h00);
        sdw(8'h11);
        t1 <= 1'b1;
        sdw(8'h11);
        rdchk(psd_pkg::ADR_SHUTDOWN, 8'h91, "flag held");
        pins(4'hA, 4'hF);
        t1 <= 1'b0;
        repeat (3) @(posedge clk);
        rdchk(psd_pkg::ADR_SHUTDOWN, 8'h91, "no auto clear");
        sdw(8'h11);
        rdchk(psd_pkg::ADR_SHUTDOWN, 8'h11, "flag cleared");
        pins(4'hA, 4'hF);
        period();
        pins(4'h0, 4'hF);
        $display("test firmware restart done");
        raw <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            sdw(tdat[i]);
            pins(tlvl[i], toe[i]);
        end
        sdw(8'h00);
        period();
        pins(4'hF, 4'hF);
        $display("test software shutdown done");
        raw <= 1'b0;
        wb(1'b1, psd_pkg::ADR_RESTART, 8'h80);
        wb(1'b1, psd_pkg::ADR_SYNC, 8'h01);
        sdw(8'h21);
        t2 <= 1'b1;
        repeat (3) @(posedge clk);
        pins(4'h0, 4'hF);
        tsync_pulse();
        repeat (2) @(posedge clk);
        pins(4'hA, 4'hF);
        t2 <= 1'b0;
        tsync_pulse();
        repeat (3) @(posedge clk);
        period();
        pins(4'h0, 4'hF);
        wb(1'b1, psd_pkg::ADR_SYNC, 8'h00);
        $display("test comparator sync done");
        wb(1'b1, psd_pkg::ADR_CCP, 8'h8C);
        for (int n = 0; n < 4; n += 3) begin
            wb(1'b1, psd_pkg::ADR_RESTART, n[7:0]);
            rdchk(psd_pkg::ADR_RESTART, n[7:0], "restart reg");
            repeat (n + 3) @(posedge clk);
            raw <= 1'b1;
            k = 0;
            do begin
                @(posedge clk);
                #1;
                k++;
                if (k == 1) check("fall b", 8'h00, {7'h0, pad[1]});
            end while (pad[0] !== 1'b1 && k < 200);
            check("rise delay", n[7:0] + 8'h01, k[7:0]);
            @(posedge clk);
            raw <= 1'b0;
        end
        wb(1'b1, psd_pkg::ADR_RESTART, 8'h05);
        repeat (8) @(posedge clk);
        raw <= 1'b1;
        repeat (2) @(posedge clk);
        raw <= 1'b0;
        hi = 1'b0;
        repeat (10) begin
            @(posedge clk);
            #1;
            hi |= pad[0];
        end
        check("blank a", 8'h00, {7'h0, hi});
        $display("test dead band done");
        stop_test();
    end
endmodule : psd_top_tb
